// file: sfp_defs.svh
// Shared constants for the serial frame port: fields, codes, reset values, timing
// How it works
// - Device samples serial_in on serial clock falls
// - Host keeps write-only frames at 50 MHz max
// - Host keeps read or convert frames at 20 MHz max
// - Frame select low; sixteen falling edges per frame
// - Device changes serial_out on serial clock rises
// - Outgoing MSB appears when frame select falls
// - Advance only on a rise following a fall
// - Readback, results and temperature go out serially
// - Reset pin low restores defaults asynchronously
// - Each of eight pins: DAC, ADC, input, output
// - Pin seven can show conversion busy
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

// Frame length
`define SFP_LAST_BIT        5'h0F
`define SFP_FRAME_BITS      5'h10
`define SFP_HOST_LAST_BIT   4'hF

// Command word fields
`define SFP_CMD_MSB         15
`define SFP_CMD_LSB         12
`define SFP_PIN_MSB         10
`define SFP_PIN_LSB         8
`define SFP_MODE_MSB        1
`define SFP_MODE_LSB        0
`define SFP_GPIO_MSB        7
`define SFP_GPIO_LSB        0
`define SFP_BUSY_EN_BIT     0
`define SFP_SEL_MSB         1
`define SFP_SEL_LSB         0

// Command codes
`define SFP_CMD_CFG         4'h1
`define SFP_CMD_GPIO        4'h2
`define SFP_CMD_BUSY        4'h3
`define SFP_CMD_CONVERT     4'h4
`define SFP_CMD_READSEL     4'h5

// Reset values
`define SFP_PIN_MODE_RST    16'hAAAA
`define SFP_GPIO_RST        8'h00
`define SFP_WORD_RST        16'h0000

// Timing: reference clock and link clock limits
`define SFP_REF_CLK_MHZ     40
`define SFP_WRITE_SCLK_MHZ  50
`define SFP_READ_SCLK_MHZ   20
`define SFP_SCLK_HALF_NS    200
`define SFP_HALF_CYC        ((`SFP_SCLK_HALF_NS * `SFP_REF_CLK_MHZ + 999) / 1000)

`endif

// file: sfp_pkg.sv
// Types shared by both ends of the serial frame port
package sfp_pkg;

  // Role of one configurable pin
  typedef enum logic [1:0] {
    MODE_DAC  = 2'h0,
    MODE_ADC  = 2'h1,
    MODE_DIN  = 2'h2,
    MODE_DOUT = 2'h3
  } pin_mode_type;

  // Source of the outgoing word
  typedef enum logic [1:0] {
    SEL_CONFIG = 2'h0,
    SEL_GPIO   = 2'h1,
    SEL_ADC    = 2'h2,
    SEL_TEMP   = 2'h3
  } read_sel_type;

  // Host frame sequencer
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_LEAD = 6'b000010,
    H_HIGH = 6'b000100,
    H_LOW  = 6'b001000,
    H_TAIL = 6'b010000,
    H_GAP  = 6'b100000
  } host_state_type;

endpackage

// file: sfp_link_if.sv
// Serial link between the host and the device
`timescale 1ns/1ps
`default_nettype none
interface sfp_link_if;
  logic sclk;
  logic frame_n;
  logic serial_in;
  logic serial_out;
  logic reset_n;

  // Host drives clock, frame, data and reset
  modport host_end (
    output sclk,
    output frame_n,
    output serial_in,
    output reset_n,
    input  serial_out
  );

  // Device only drives its serial output
  modport dev_end (
    input  sclk,
    input  frame_n,
    input  serial_in,
    input  reset_n,
    output serial_out
  );
endinterface
`default_nettype wire

// file: sfp_pair_buf.sv
// Small valid/ready FIFO used in the host's word path
`timescale 1ns/1ps
`default_nettype none
module sfp_pair_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Filling side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Draining side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push;
  wire              pop;

  // Handshake decode
  assign in_ready_o  = (cnt_q != FULL);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage array
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end

  // Pointers and fill level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: sfp_device.sv
// Device end: frame capture, serial readback and pin configuration
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defs.svh"
module sfp_device
  import sfp_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  // Link to the host
  sfp_link_if.dev_end      LINK,
  // Received words
  output logic [15:0]      RX_DATA_O,
  output logic             RX_VALID_O,
  // Conversion handshake and data sources
  output logic             CONV_START_O,
  input  wire logic        CONV_DONE_I,
  input  wire logic [15:0] ADC_DATA_I,
  input  wire logic [15:0] TEMP_DATA_I,
  // Configurable pins
  input  wire logic [7:0]  IO_IN_I,
  output logic [7:0]       IO_OUT_O,
  output logic [7:0]       IO_OE_O,
  output logic [15:0]      PIN_MODE_O,
  output logic             BUSY_O
);
  // Synchronisers for everything that arrives from the pins except the reset pin
  logic [1:0]  sclk_sync_q;
  logic [1:0]  frame_sync_q;
  logic [1:0]  sin_sync_q;
  logic [7:0]  io_meta_q;
  logic [7:0]  io_sync_q;
  logic        sclk_prev_q;
  logic        frame_prev_q;

  // Frame state
  logic [4:0]  bit_cnt_q;
  logic [4:0]  bit_cnt_d;
  logic [15:0] rx_shift_q;
  logic [15:0] rx_shift_d;
  logic        fall_seen_q;
  logic        fall_seen_d;
  logic [15:0] tx_q;
  logic [15:0] tx_d;

  // Configuration state
  logic [15:0] pin_mode_q;
  logic [7:0]  gpio_q;
  logic        busy_en_q;
  logic        busy_q;
  logic [1:0]  read_sel_q;
  logic [15:0] adc_q;
  logic [15:0] word_q;
  logic        word_valid_q;
  logic        conv_start_q;

  // Edge and frame decode
  wire         sclk_now   = sclk_sync_q[1];
  wire         frame_low  = ~frame_sync_q[1];
  wire         sclk_fall  = sclk_prev_q & ~sclk_now;
  wire         sclk_rise  = ~sclk_prev_q & sclk_now;
  wire         frame_fall = frame_prev_q & frame_low;
  wire         take_bit   = sclk_fall & frame_low & (bit_cnt_q < `SFP_FRAME_BITS);
  wire         word_done  = take_bit & (bit_cnt_q == `SFP_LAST_BIT);
  wire         shift_out  = sclk_rise & frame_low & fall_seen_q;
  wire [15:0]  word_in    = {rx_shift_q[14:0], sin_sync_q[1]};

  // Command decode of a finished word
  wire [3:0]   cmd        = word_in[`SFP_CMD_MSB:`SFP_CMD_LSB];
  wire [2:0]   pin_idx    = word_in[`SFP_PIN_MSB:`SFP_PIN_LSB];
  wire [1:0]   new_mode   = word_in[`SFP_MODE_MSB:`SFP_MODE_LSB];
  wire         do_cfg     = word_done & (cmd == `SFP_CMD_CFG);
  wire         do_gpio    = word_done & (cmd == `SFP_CMD_GPIO);
  wire         do_busy    = word_done & (cmd == `SFP_CMD_BUSY);
  wire         do_conv    = word_done & (cmd == `SFP_CMD_CONVERT);
  wire         do_sel     = word_done & (cmd == `SFP_CMD_READSEL);

  // Readback source for the next frame
  logic [15:0] read_word;
  always_comb
  begin
    case (read_sel_type'(read_sel_q))
      SEL_CONFIG: read_word = pin_mode_q;
      SEL_GPIO:   read_word = {8'h00, io_sync_q};
      SEL_ADC:    read_word = adc_q;
      SEL_TEMP:   read_word = TEMP_DATA_I;
      default:    read_word = `SFP_WORD_RST;
    endcase
  end

  // Next values of the frame shifters
  always_comb
  begin
    bit_cnt_d   = bit_cnt_q;
    rx_shift_d  = rx_shift_q;
    fall_seen_d = fall_seen_q;
    tx_d        = tx_q;
    if (!frame_low)
    begin
      bit_cnt_d   = '0;
      fall_seen_d = 1'b0;
    end
    else
    begin
      if (take_bit)
      begin
        rx_shift_d = word_in;
        bit_cnt_d  = bit_cnt_q + 5'h01;
      end
      if (sclk_fall)
        fall_seen_d = 1'b1;
      else if (shift_out)
        fall_seen_d = 1'b0;
    end
    if (frame_fall)
      tx_d = read_word;
    else if (shift_out)
      tx_d = {tx_q[14:0], 1'b0};
  end

  // Pin synchronisers; the reset pin clears them at once
  always_ff @(posedge REF_CLK_I or negedge LINK.reset_n)
  begin
    if (!LINK.reset_n)
    begin
      sclk_sync_q  <= 2'h0;
      frame_sync_q <= 2'h3;
      sin_sync_q   <= 2'h0;
      io_meta_q    <= 8'h00;
      io_sync_q    <= 8'h00;
      sclk_prev_q  <= 1'b0;
      frame_prev_q <= 1'b1;
    end
    else
    begin
      sclk_sync_q  <= {sclk_sync_q[0], LINK.sclk};
      frame_sync_q <= {frame_sync_q[0], LINK.frame_n};
      sin_sync_q   <= {sin_sync_q[0], LINK.serial_in};
      io_meta_q    <= IO_IN_I;
      io_sync_q    <= io_meta_q;
      sclk_prev_q  <= sclk_now;
      frame_prev_q <= frame_sync_q[1];
    end
  end

  // Frame shifters
  always_ff @(posedge REF_CLK_I or negedge LINK.reset_n)
  begin
    if (!LINK.reset_n)
    begin
      bit_cnt_q   <= 5'h00;
      rx_shift_q  <= `SFP_WORD_RST;
      fall_seen_q <= 1'b0;
      tx_q        <= `SFP_WORD_RST;
    end
    else if (RST_I)
    begin
      bit_cnt_q   <= 5'h00;
      rx_shift_q  <= `SFP_WORD_RST;
      fall_seen_q <= 1'b0;
      tx_q        <= `SFP_WORD_RST;
    end
    else
    begin
      bit_cnt_q   <= bit_cnt_d;
      rx_shift_q  <= rx_shift_d;
      fall_seen_q <= fall_seen_d;
      tx_q        <= tx_d;
    end
  end

  // Configuration registers, restored by the reset pin
  always_ff @(posedge REF_CLK_I or negedge LINK.reset_n)
  begin
    if (!LINK.reset_n)
    begin
      pin_mode_q <= `SFP_PIN_MODE_RST;
      gpio_q     <= `SFP_GPIO_RST;
      busy_en_q  <= 1'b0;
      read_sel_q <= 2'h0;
    end
    else if (RST_I)
    begin
      pin_mode_q <= `SFP_PIN_MODE_RST;
      gpio_q     <= `SFP_GPIO_RST;
      busy_en_q  <= 1'b0;
      read_sel_q <= 2'h0;
    end
    else
    begin
      if (do_cfg)
        pin_mode_q[{pin_idx, 1'b0} +: 2] <= new_mode;
      if (do_gpio)
        gpio_q <= word_in[`SFP_GPIO_MSB:`SFP_GPIO_LSB];
      if (do_busy)
        busy_en_q <= word_in[`SFP_BUSY_EN_BIT];
      if (do_sel)
        read_sel_q <= word_in[`SFP_SEL_MSB:`SFP_SEL_LSB];
    end
  end

  // Conversion tracking and word hand-off
  always_ff @(posedge REF_CLK_I or negedge LINK.reset_n)
  begin
    if (!LINK.reset_n)
    begin
      busy_q       <= 1'b0;
      adc_q        <= `SFP_WORD_RST;
      word_q       <= `SFP_WORD_RST;
      word_valid_q <= 1'b0;
      conv_start_q <= 1'b0;
    end
    else if (RST_I)
    begin
      busy_q       <= 1'b0;
      adc_q        <= `SFP_WORD_RST;
      word_q       <= `SFP_WORD_RST;
      word_valid_q <= 1'b0;
      conv_start_q <= 1'b0;
    end
    else
    begin
      busy_q       <= do_conv | (busy_q & ~CONV_DONE_I);
      conv_start_q <= do_conv;
      word_valid_q <= word_done;
      if (word_done)
        word_q <= word_in;
      if (busy_q & CONV_DONE_I)
        adc_q <= ADC_DATA_I;
    end
  end

  // Per-pin drive, with pin seven optionally showing busy
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      wire is_out  = (pin_mode_q[2*gi +: 2] == MODE_DOUT);
      wire as_busy = (gi == 7) && busy_en_q;
      assign IO_OE_O[gi]  = is_out | as_busy;
      assign IO_OUT_O[gi] = as_busy ? busy_q : gpio_q[gi];
    end
  endgenerate

  // Outputs
  assign LINK.serial_out = tx_q[15];
  assign RX_DATA_O       = word_q;
  assign RX_VALID_O      = word_valid_q;
  assign CONV_START_O    = conv_start_q;
  assign PIN_MODE_O      = pin_mode_q;
  assign BUSY_O          = busy_q;
endmodule
`default_nettype wire

// file: sfp_host.sv
// Host end: makes the serial clock and frames queued words
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defs.svh"
module sfp_host
  import sfp_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  // Words to send
  input  wire logic [15:0] TX_DATA_I,
  input  wire logic        TX_VALID_I,
  output logic             TX_READY_O,
  // Words received
  output logic [15:0]      RX_DATA_O,
  output logic             RX_VALID_O,
  // Device reset request
  input  wire logic        DEV_RESET_I,
  // Link to the device
  sfp_link_if.host_end     LINK
);
  localparam logic [3:0] HALF_LAST = 4'(`SFP_HALF_CYC - 1);

  host_state_type state_q;
  host_state_type state_d;
  logic [3:0]  cnt_q;
  logic [3:0]  bits_q;
  logic [3:0]  bits_d;
  logic [15:0] tx_q;
  logic [15:0] tx_d;
  logic [15:0] rx_q;
  logic [15:0] rx_d;
  logic        sclk_q;
  logic        sclk_d;
  logic        frame_n_q;
  logic        frame_n_d;
  logic        rx_valid_q;
  logic        rx_valid_d;
  logic        reset_n_q;
  logic [1:0]  sout_sync_q;
  logic        buf_valid;
  logic [15:0] buf_data;

  // Queue of words waiting for a frame
  sfp_pair_buf #(
    .WIDTH (16),
    .DEPTH (2)
  ) u_buf (
    .clk_i       (REF_CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (TX_VALID_I),
    .in_data_i   (TX_DATA_I),
    .in_ready_o  (TX_READY_O),
    .out_valid_o (buf_valid),
    .out_data_o  (buf_data),
    .out_ready_i (state_q == H_IDLE)
  );

  wire tick = (cnt_q == HALF_LAST);
  wire sout = sout_sync_q[1];

  // Frame sequencer
  always_comb
  begin
    state_d    = state_q;
    bits_d     = bits_q;
    tx_d       = tx_q;
    rx_d       = rx_q;
    sclk_d     = sclk_q;
    frame_n_d  = frame_n_q;
    rx_valid_d = 1'b0;
    case (state_q)
      H_IDLE:
        if (buf_valid)
        begin
          tx_d      = buf_data;
          frame_n_d = 1'b0;
          bits_d    = 4'h0;
          state_d   = H_LEAD;
        end
      H_LEAD:
        if (tick)
        begin
          sclk_d  = 1'b1;
          state_d = H_HIGH;
        end
      H_HIGH:
        if (tick)
        begin
          sclk_d  = 1'b0;
          rx_d    = {rx_q[14:0], sout};
          bits_d  = bits_q + 4'h1;
          state_d = (bits_q == `SFP_HOST_LAST_BIT) ? H_TAIL : H_LOW;
        end
      H_LOW:
        if (tick)
        begin
          sclk_d  = 1'b1;
          tx_d    = {tx_q[14:0], 1'b0};
          state_d = H_HIGH;
        end
      H_TAIL:
        if (tick)
        begin
          frame_n_d  = 1'b1;
          rx_valid_d = 1'b1;
          state_d    = H_GAP;
        end
      H_GAP:
        if (tick)
          state_d = H_IDLE;
      default:
        state_d = H_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      state_q    <= H_IDLE;
      cnt_q      <= 4'h0;
      bits_q     <= 4'h0;
      tx_q       <= `SFP_WORD_RST;
      rx_q       <= `SFP_WORD_RST;
      sclk_q     <= 1'b0;
      frame_n_q  <= 1'b1;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      cnt_q      <= (state_q != state_d || tick) ? 4'h0 : cnt_q + 4'h1;
      bits_q     <= bits_d;
      tx_q       <= tx_d;
      rx_q       <= rx_d;
      sclk_q     <= sclk_d;
      frame_n_q  <= frame_n_d;
      rx_valid_q <= rx_valid_d;
    end
  end

  // Device reset drive and serial output synchroniser
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      reset_n_q   <= 1'b0;
      sout_sync_q <= 2'h0;
    end
    else
    begin
      reset_n_q   <= ~DEV_RESET_I;
      sout_sync_q <= {sout_sync_q[0], LINK.serial_out};
    end
  end

  // Pin and user outputs
  assign LINK.sclk      = sclk_q;
  assign LINK.frame_n   = frame_n_q;
  assign LINK.serial_in = tx_q[15];
  assign LINK.reset_n   = reset_n_q;
  assign RX_DATA_O      = rx_q;
  assign RX_VALID_O     = rx_valid_q;
endmodule
`default_nettype wire

// file: sfp_props.sv
// Concurrent checks on the serial link between host and device
`timescale 1ns/1ps
`default_nettype none
module sfp_props (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Link signals
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic reset_n
);
  logic       sclk_q;
  logic       frame_q;
  logic [4:0] falls_q;
  logic [3:0] since_q;

  // Edge history, falls in a frame, cycles since the last shift cause
  always_ff @(posedge REF_CLK_I)
  begin
    sclk_q  <= sclk;
    frame_q <= frame_n;
    falls_q <= (RST_I || frame_n) ? 5'h00 : falls_q + {4'h0, sclk_q & ~sclk};
    since_q <= (RST_I || (sclk & ~sclk_q) || (frame_q & ~frame_n)) ? 4'h0 :
               since_q + {3'h0, since_q != 4'hF};
  end

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  a_idle_clock_low: assert property (frame_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  a_sixteen_falls: assert property ($rose(frame_n) |-> falls_q == 5'h10)
    else $error("frame did not hold sixteen falling edges");
  a_high_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high half not eight cycles");
  a_low_half: assert property ($fell(sclk) && !frame_n |-> !sclk [*8])
    else $error("serial clock low half too short");
  a_in_settled: assert property ($rose(sclk) |=> $stable(serial_in) [*8])
    else $error("serial input moved before the falling edge");
  a_frame_gap: assert property ($rose(frame_n) |-> frame_n [*3])
    else $error("frame select high for under three cycles");
  a_lead_before_clock: assert property ($fell(frame_n) |-> !sclk [*8] ##1 sclk)
    else $error("first clock edge came too soon after frame start");
  a_out_after_rise: assert property (!frame_n && $changed(serial_out) |-> since_q < 4'h8)
    else $error("serial output changed away from a rising edge");
  a_out_hold_fall: assert property ($fell(sclk) && !frame_n |-> $stable(serial_out) [*4])
    else $error("serial output moved around a falling edge");
  a_reset_release: assert property ($fell(RST_I) |-> !reset_n && frame_n && !sclk)
    else $error("link not idle at reset release");

  // Main scenarios
  c_frame_done: cover property ($rose(frame_n));
  c_out_high: cover property ($fell(sclk) && !frame_n && serial_out);
  c_dev_reset: cover property ($fell(reset_n));
endmodule
`default_nettype wire

// file: tb_top.sv
// Testbench joining host and device ends, plus a faulty-host link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] tx_data = 16'h0000;
  logic        tx_valid = 1'b0;
  logic        tx_ready;
  logic        dev_reset = 1'b0;
  logic        conv_done = 1'b0;
  logic [15:0] adc_data = 16'h0000;
  logic [15:0] temp_data = 16'hC3A5;
  logic [7:0]  io_in = 8'h00;
  logic [15:0] h_rx, d_rx, d2_rx, pin_mode, h_last;
  logic        h_val, d_val, d2_val, conv_start, busy;
  logic [7:0]  io_out, io_oe;
  logic [15:0] conv_cnt = 16'h0000;
  logic [15:0] d2_cnt = 16'h0000;
  logic [15:0] d_q[$];
  int          h_cnt = 0;
  int          bad_count = 0;
  int          checks_done = 0;

  sfp_link_if lk ();
  sfp_link_if lk2 ();

  // Reference clock
  always #12.5 clk = ~clk;

  // Ends under test, plus a second device driven by the bench
  sfp_host i_sfp_host (.REF_CLK_I(clk), .RST_I(rst), .TX_DATA_I(tx_data), .TX_VALID_I(tx_valid),
    .TX_READY_O(tx_ready), .RX_DATA_O(h_rx), .RX_VALID_O(h_val), .DEV_RESET_I(dev_reset),
    .LINK(lk.host_end));
  sfp_device i_sfp_device (.REF_CLK_I(clk), .RST_I(rst), .LINK(lk.dev_end), .RX_DATA_O(d_rx),
    .RX_VALID_O(d_val), .CONV_START_O(conv_start), .CONV_DONE_I(conv_done),
    .ADC_DATA_I(adc_data), .TEMP_DATA_I(temp_data), .IO_IN_I(io_in), .IO_OUT_O(io_out),
    .IO_OE_O(io_oe), .PIN_MODE_O(pin_mode), .BUSY_O(busy));
  sfp_device i_sfp_device_b (.REF_CLK_I(clk), .RST_I(rst), .LINK(lk2.dev_end),
    .RX_DATA_O(d2_rx), .RX_VALID_O(d2_val), .CONV_START_O(), .CONV_DONE_I(conv_done),
    .ADC_DATA_I(adc_data), .TEMP_DATA_I(temp_data), .IO_IN_I(io_in), .IO_OUT_O(),
    .IO_OE_O(), .PIN_MODE_O(), .BUSY_O());
  sfp_props i_sfp_props (.REF_CLK_I(clk), .RST_I(rst), .sclk(lk.sclk), .frame_n(lk.frame_n),
    .serial_in(lk.serial_in), .serial_out(lk.serial_out), .reset_n(lk.reset_n));

  // Collect received words and start pulses
  always @(posedge clk)
  begin
    if (h_val === 1'b1) begin h_last <= h_rx; h_cnt <= h_cnt + 1; end
    if (d_val === 1'b1) d_q.push_back(d_rx);
    if (d2_val === 1'b1) d2_cnt <= d2_cnt + 16'h0001;
    if (conv_start === 1'b1) conv_cnt <= conv_cnt + 16'h0001;
  end

  task check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One word through the host queue, waiting for the whole frame
  task send(input logic [15:0] w);
    int n;
    int k;
    n = h_cnt;
    k = 0;
    tx_data  <= w;
    tx_valid <= 1'b1;
    do @(posedge clk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    while (h_cnt == n && k < 800) begin @(posedge clk); k++; end
    check("send_done", {15'h0000, k < 800}, 16'h0001);
    check("dev_word", d_q[$], w);
  endtask

  // Faulty host on the second link: bit count chosen by the caller
  task bang(input logic [15:0] w, input int falls);
    lk2.serial_in <= w[15];
    lk2.frame_n   <= 1'b0;
    for (int i = 0; i < falls; i++)
    begin
      repeat (4) @(posedge clk);
      lk2.sclk <= 1'b1;
      if (i > 0) lk2.serial_in <= w[(31 - i) % 16];
      repeat (4) @(posedge clk);
      lk2.sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    lk2.frame_n   <= 1'b1;
    lk2.serial_in <= ~lk2.serial_in;
    repeat (8) @(posedge clk);
  endtask

  task t_reset;
    check("rst_modes", pin_mode, 16'hAAAA);
    check("rst_pins", {io_oe, io_out}, 16'h0000);
    $display("reset test done");
  endtask

  task t_fault;
    logic [15:0] n;
    n = d2_cnt;
    bang(16'h1234, 8);
    check("abort_words", d2_cnt - n, 16'h0000);
    bang(16'hC3A1, 18);
    check("extra_words", d2_cnt - n, 16'h0001);
    check("extra_value", d2_rx, 16'hC3A1);
    $display("fault test done");
  endtask

  task t_config;
    for (int p = 0; p < 8; p++) send({4'h1, 1'b0, p[2:0], 6'h00, p[1:0]});
    check("modes", pin_mode, 16'hE4E4);
    io_in <= 8'h5A;
    send(16'h20A5);
    check("out_en", {14'h0000, io_oe[7], io_oe[3]}, 16'h0003);
    check("out_val", {14'h0000, io_out[7], io_out[3]}, 16'h0002);
    $display("config test done");
  endtask

  task t_readback;
    logic [15:0] exp [3];
    logic [1:0]  sel [3];
    exp = '{16'hE4E4, 16'h005A, 16'hC3A5};
    sel = '{2'h0, 2'h1, 2'h3};
    for (int k = 0; k < 3; k++)
    begin
      send({4'h5, 10'h000, sel[k]});
      send(16'h0000);
      check("readback", h_last, exp[k]);
    end
    $display("readback test done");
  endtask

  task t_convert;
    send(16'h3001);
    send(16'h4000);
    check("starts", conv_cnt, 16'h0001);
    check("busy_on", {15'h0000, busy}, 16'h0001);
    check("pin7_busy", {14'h0000, io_oe[7], io_out[7]}, 16'h0003);
    adc_data  <= 16'h9E37;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge clk);
    check("busy_off", {15'h0000, busy}, 16'h0000);
    check("pin7_idle", {14'h0000, io_oe[7], io_out[7]}, 16'h0002);
    send(16'h5002);
    send(16'h0000);
    check("adc_result", h_last, 16'h9E37);
    $display("convert test done");
  endtask

  task t_burst;
    int base;
    int h0;
    int k;
    logic [15:0] refused;
    base    = d_q.size();
    h0      = h_cnt;
    refused = 16'h0000;
    for (int i = 0; i < 4; i++)
    begin
      tx_data  <= {12'h0A5, i[3:0]};
      tx_valid <= 1'b1;
      do begin @(posedge clk); if (tx_ready !== 1'b1) refused = 16'h0001; end
      while (tx_ready !== 1'b1);
    end
    tx_valid <= 1'b0;
    k = 0;
    while (h_cnt < h0 + 4 && k < 1500) begin @(posedge clk); k++; end
    check("burst_done", {15'h0000, k < 1500}, 16'h0001);
    check("refused", refused, 16'h0001);
    for (int i = 0; i < 4; i++) check("burst", d_q[base + i], {12'h0A5, i[3:0]});
    $display("burst test done");
  endtask

  task t_dev_reset;
    dev_reset <= 1'b1;
    repeat (4) @(posedge clk);
    check("pin_modes", pin_mode, 16'hAAAA);
    check("pin_drive", {8'h00, io_oe}, 16'h0000);
    dev_reset <= 1'b0;
    repeat (8) @(posedge clk);
    send(16'h0000);
    check("default_source", h_last, 16'hAAAA);
    $display("device reset test done");
  endtask

  // Main sequence
  initial
  begin
    lk2.sclk      <= 1'b0;
    lk2.frame_n   <= 1'b1;
    lk2.serial_in <= 1'b0;
    lk2.reset_n   <= 1'b0;
    repeat (8) @(posedge clk);
    rst         <= 1'b0;
    lk2.reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset;
    t_fault;
    t_config;
    t_readback;
    t_convert;
    t_burst;
    t_dev_reset;
    results;
  end

  // Watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    results;
  end
endmodule
`default_nettype wire
